//--- include/alb_pkg.sv
// Purpose: shared constants and types for the alu and branch subset
// Assumes: 16-bit data words, status flags supplied by the core
// Notes on behaviour
// - add with carry: operand, working reg, carry
// - long literal add with carry, five flags
// - one-step arith shift keeps sign, updates carry, negative, wrap, zero
// - multi-step arith shift: only negative, zero
// - flag to bit write, flags unchanged
// - signed ge, gt, lt branches from flags
// - unsigned ge, gt branches from carry, zero
// - signed le branch from flags
// - unsigned lt, le branches from carry, zero
// - single flag branches, either polarity
// - sign branches look only at negative
// - bit test skip if clear, 2 or 3
package alb_pkg;
   localparam int ALB_W = 16;
   localparam int ALB_LONG_LIT_W = 10;
   localparam int ALB_DIGIT_CARRY_POS = 4;
   localparam logic [1:0] ALB_CYC_ONE = 2'h1;
   localparam logic [1:0] ALB_CYC_TWO = 2'h2;
   localparam logic [1:0] ALB_CYC_THREE = 2'h3;
   localparam logic [1:0] ALB_WORDS_ONE = 2'h1;
   localparam logic [1:0] ALB_CNT_RST = 2'h0;
   localparam logic [15:0] ALB_RES_RST = 16'h0000;

   typedef enum logic [3:0] {
      ALB_OP_NOP = 4'h0,
      ALB_OP_ADD_CARRY = 4'h1,
      ALB_OP_ADD_CARRY_LIT = 4'h2,
      ALB_OP_SHIFT_ONE = 4'h3,
      ALB_OP_SHIFT_MULTI = 4'h4,
      ALB_OP_FLAG_WRITE = 4'h5,
      ALB_OP_BIT_CLEAR = 4'h6,
      ALB_OP_BIT_SET = 4'h7,
      ALB_OP_BIT_TOGGLE = 4'h8,
      ALB_OP_BIT_SKIP = 4'h9,
      ALB_OP_BRANCH_COND = 4'hA,
      ALB_OP_BRANCH = 4'hB,
      ALB_OP_BRANCH_COMPUTED = 4'hC
   } alb_op_t;

   typedef enum logic [3:0] {
      ALB_CC_CARRY = 4'h0,
      ALB_CC_NO_CARRY = 4'h1,
      ALB_CC_SGE = 4'h2,
      ALB_CC_SGT = 4'h3,
      ALB_CC_SLE = 4'h4,
      ALB_CC_SLT = 4'h5,
      ALB_CC_UNSIGNED_AT_LEAST = 4'h6,
      ALB_CC_UGT = 4'h7,
      ALB_CC_ULE = 4'h8,
      ALB_CC_UNSIGNED_BELOW = 4'h9,
      ALB_CC_NEG = 4'hA,
      ALB_CC_SIGN_CLEAR = 4'hB,
      ALB_CC_WRAP = 4'hC,
      ALB_CC_NO_WRAP = 4'hD,
      ALB_CC_ZERO = 4'hE,
      ALB_CC_NOT_ZERO = 4'hF
   } alb_cond_t;

   typedef struct packed {
      logic carry;
      logic digit_carry_flag;
      logic neg;
      logic signed_wrap_flag;
      logic zero;
   } alb_flags_t;

   localparam alb_flags_t ALB_FLAGS_RST = '0;

   typedef struct packed {
      alb_op_t op;
      alb_cond_t cond;
      logic [15:0] opnd_a;
      logic [15:0] opnd_b;
      logic [4:0] bit_pos;
      logic take_zero;
   } alb_req_t;
endpackage

//--- sim/alb_core_tb.sv
// Purpose: self-checking bench for the alu and branch subset core
// Assumes: one request per cycle, answer one cycle later, no back-pressure
// Notes: expected values are built here from operands and flags
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import alb_pkg::*;
   logic ref_clk_i;
   logic reset_n_i;
   logic req_valid_i;
   alb_req_t req_i;
   alb_flags_t flags_i;
   logic next_two_word_i;
   logic done_o;
   logic res_we_o;
   logic redirect_o;
   logic skip_o;
   logic [15:0] res_o;
   alb_flags_t flags_o;
   logic [1:0] cycles_o;
   logic [1:0] words_o;
   int err_total = 0;
   int cmp_count = 0;

   alb_core #(.DATA_W(16)) DUT (
      .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .req_valid_i(req_valid_i),
      .req_i(req_i), .flags_i(flags_i), .next_two_word_i(next_two_word_i),
      .done_o(done_o), .res_o(res_o), .res_we_o(res_we_o), .flags_o(flags_o),
      .redirect_o(redirect_o), .skip_o(skip_o), .cycles_o(cycles_o), .words_o(words_o)
   );

   initial begin
      ref_clk_i = 1'b0;
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end

   task automatic results;
      if (err_total == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] want);
      cmp_count++;
      if (seen !== want) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, want, seen);
      end
   endtask

   function automatic alb_req_t rq(input alb_op_t op, input alb_cond_t cc, input logic [15:0] a,
                                   input logic [15:0] b, input logic [4:0] bp, input logic tz);
      rq.op = op;
      rq.cond = cc;
      rq.opnd_a = a;
      rq.opnd_b = b;
      rq.bit_pos = bp;
      rq.take_zero = tz;
   endfunction

   // sum with carry in; returns {carry, digit carry, neg, wrap, zero, result}
   function automatic logic [20:0] add_ref(input logic [15:0] a, input logic [15:0] b,
                                           input logic c);
      logic [16:0] s;
      logic [4:0] n;
      logic ov;
      s = {1'b0, a} + {1'b0, b} + 17'(c);
      n = {1'b0, a[3:0]} + {1'b0, b[3:0]} + 5'(c);
      ov = (a[15] == b[15]) && (s[15] != a[15]);
      add_ref = {s[16], n[4], s[15], ov, s[15:0] == 16'h0000, s[15:0]};
   endfunction

   function automatic logic cc_ref(input alb_cond_t c, input alb_flags_t f);
      logic lt;
      lt = f.neg ^ f.signed_wrap_flag;
      case (c)
         ALB_CC_CARRY: cc_ref = f.carry;
         ALB_CC_NO_CARRY: cc_ref = !f.carry;
         ALB_CC_SGE: cc_ref = !lt;
         ALB_CC_SGT: cc_ref = !lt && !f.zero;
         ALB_CC_SLE: cc_ref = lt || f.zero;
         ALB_CC_SLT: cc_ref = lt;
         ALB_CC_UNSIGNED_AT_LEAST: cc_ref = f.carry;
         ALB_CC_UGT: cc_ref = f.carry && !f.zero;
         ALB_CC_ULE: cc_ref = !f.carry || f.zero;
         ALB_CC_UNSIGNED_BELOW: cc_ref = !f.carry;
         ALB_CC_NEG: cc_ref = f.neg;
         ALB_CC_SIGN_CLEAR: cc_ref = !f.neg;
         ALB_CC_WRAP: cc_ref = f.signed_wrap_flag;
         ALB_CC_NO_WRAP: cc_ref = !f.signed_wrap_flag;
         ALB_CC_ZERO: cc_ref = f.zero;
         default: cc_ref = !f.zero;
      endcase
   endfunction

   task automatic go(input alb_req_t r, input alb_flags_t f, input logic t);
      @(posedge ref_clk_i);
      req_valid_i <= 1'b1;
      req_i <= r;
      flags_i <= f;
      next_two_word_i <= t;
      #1;
   endtask

   task automatic idle;
      @(posedge ref_clk_i);
      req_valid_i <= 1'b0;
      #1;
   endtask

   task automatic ans(input logic we, input logic [15:0] res, input alb_flags_t f,
                      input logic rd, input logic sk, input logic [1:0] cy);
      chk("done", 16'(done_o), 16'h0001);
      chk("res_we", 16'(res_we_o), 16'(we));
      if (we) begin
         chk("res", res_o, res);
      end
      chk("flags", 16'(flags_o), 16'(f));
      chk("redirect", 16'(redirect_o), 16'(rd));
      chk("skip", 16'(skip_o), 16'(sk));
      chk("cycles", 16'(cycles_o), 16'(cy));
      chk("words", 16'(words_o), 16'(ALB_WORDS_ONE));
   endtask

   task automatic op1(input alb_req_t r, input alb_flags_t f, input logic t, input logic we,
                      input logic [15:0] res, input alb_flags_t fe, input logic rd,
                      input logic sk, input logic [1:0] cy);
      go(r, f, t);
      idle();
      ans(we, res, fe, rd, sk, cy);
   endtask

   task automatic t_reset;
      @(posedge ref_clk_i);
      reset_n_i <= 1'b0;
      req_valid_i <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      reset_n_i <= 1'b1;
      #1;
      chk("rst_out", {res_o, 16'(done_o), 16'(res_we_o), 16'(flags_o), 16'(cycles_o),
                      16'(words_o), 16'(redirect_o), 16'(skip_o)} == 128'h0 ?
                      16'h0000 : 16'h0001, 16'h0000);
   endtask

   task automatic t_add_with_carry;
      logic [15:0] av [4] = '{16'h7FFF, 16'hFFFF, 16'h000F, 16'h1234};
      logic [15:0] bv [4] = '{16'h0001, 16'h0000, 16'h0000, 16'h8765};
      logic [20:0] e;
      logic [20:0] e2;
      for (int i = 0; i < 4; i++) begin
         e = add_ref(av[i], bv[i], i[0]);
         op1(rq(ALB_OP_ADD_CARRY, ALB_CC_CARRY, av[i], bv[i], 5'h00, 1'b0), {i[0], 4'hF}, 1'b0,
             1'b1, e[15:0], e[20:16], 1'b0, 1'b0, ALB_CYC_ONE);
      end
      e = add_ref(16'h7FFF, 16'h0001, 1'b0);
      e2 = add_ref(16'h8000, 16'h7FFF, 1'b1);
      go(rq(ALB_OP_ADD_CARRY, ALB_CC_CARRY, 16'h7FFF, 16'h0001, 5'h00, 1'b0), 5'h0F, 1'b0);
      go(rq(ALB_OP_ADD_CARRY, ALB_CC_CARRY, 16'h8000, 16'h7FFF, 5'h00, 1'b0), 5'h10, 1'b0);
      ans(1'b1, e[15:0], e[20:16], 1'b0, 1'b0, ALB_CYC_ONE);
      idle();
      ans(1'b1, e2[15:0], e2[20:16], 1'b0, 1'b0, ALB_CYC_ONE);
      idle();
      chk("done_idle", 16'(done_o), 16'h0000);
   endtask

   task automatic t_lit;
      logic [20:0] e;
      e = add_ref(16'h03FF, 16'hFC01, 1'b1);
      op1(rq(ALB_OP_ADD_CARRY_LIT, ALB_CC_CARRY, 16'hFFFF, 16'hFC01, 5'h00, 1'b0), 5'h1F, 1'b0,
          1'b1, e[15:0], e[20:16], 1'b0, 1'b0, ALB_CYC_ONE);
      e = add_ref(16'h0005, 16'h7FFC, 1'b0);
      op1(rq(ALB_OP_ADD_CARRY_LIT, ALB_CC_CARRY, 16'h0C05, 16'h7FFC, 5'h00, 1'b0), 5'h0F, 1'b0,
          1'b1, e[15:0], e[20:16], 1'b0, 1'b0, ALB_CYC_ONE);
   endtask

   task automatic t_shift;
      op1(rq(ALB_OP_SHIFT_ONE, ALB_CC_CARRY, 16'h8001, 16'h0000, 5'h00, 1'b0), 5'h0A, 1'b0,
          1'b1, 16'hC000, 5'h1C, 1'b0, 1'b0, ALB_CYC_ONE);
      op1(rq(ALB_OP_SHIFT_ONE, ALB_CC_CARRY, 16'h0001, 16'h0000, 5'h00, 1'b0), 5'h03, 1'b0,
          1'b1, 16'h0000, 5'h11, 1'b0, 1'b0, ALB_CYC_ONE);
      op1(rq(ALB_OP_SHIFT_MULTI, ALB_CC_CARRY, 16'h8000, 16'h0000, 5'h04, 1'b0), 5'h1B, 1'b0,
          1'b1, 16'hF800, 5'h1E, 1'b0, 1'b0, ALB_CYC_ONE);
      op1(rq(ALB_OP_SHIFT_MULTI, ALB_CC_CARRY, 16'h8000, 16'h0000, 5'h14, 1'b0), 5'h01, 1'b0,
          1'b1, 16'hFFFF, 5'h04, 1'b0, 1'b0, ALB_CYC_ONE);
      op1(rq(ALB_OP_SHIFT_MULTI, ALB_CC_CARRY, 16'h4000, 16'h0000, 5'h0F, 1'b0), 5'h1E, 1'b0,
          1'b1, 16'h0000, 5'h1B, 1'b0, 1'b0, ALB_CYC_ONE);
   endtask

   task automatic t_bits;
      op1(rq(ALB_OP_FLAG_WRITE, ALB_CC_CARRY, 16'h0000, 16'h000F, 5'h00, 1'b0), 5'h10, 1'b0,
          1'b1, 16'h8000, 5'h10, 1'b0, 1'b0, ALB_CYC_ONE);
      op1(rq(ALB_OP_FLAG_WRITE, ALB_CC_CARRY, 16'hFFFF, 16'h0003, 5'h00, 1'b1), 5'h10, 1'b0,
          1'b1, 16'hFFF7, 5'h10, 1'b0, 1'b0, ALB_CYC_ONE);
      op1(rq(ALB_OP_BIT_CLEAR, ALB_CC_CARRY, 16'hFFFF, 16'h0000, 5'h0F, 1'b0), 5'h15, 1'b0,
          1'b1, 16'h7FFF, 5'h15, 1'b0, 1'b0, ALB_CYC_ONE);
      op1(rq(ALB_OP_BIT_SET, ALB_CC_CARRY, 16'h0000, 16'h0000, 5'h00, 1'b0), 5'h0A, 1'b0,
          1'b1, 16'h0001, 5'h0A, 1'b0, 1'b0, ALB_CYC_ONE);
      op1(rq(ALB_OP_BIT_TOGGLE, ALB_CC_CARRY, 16'h01FF, 16'h0000, 5'h10, 1'b0), 5'h1F, 1'b0,
          1'b1, 16'h01FE, 5'h1F, 1'b0, 1'b0, ALB_CYC_ONE);
      // idle code and an undefined code answer with done only
      op1(rq(ALB_OP_NOP, ALB_CC_CARRY, 16'h0000, 16'h0000, 5'h00, 1'b0), 5'h15, 1'b0,
          1'b0, 16'h0000, 5'h15, 1'b0, 1'b0, ALB_CYC_ONE);
      op1(rq(alb_op_t'(4'hD), ALB_CC_CARRY, 16'h0000, 16'h0000, 5'h00, 1'b0), 5'h0A, 1'b0,
          1'b0, 16'h0000, 5'h0A, 1'b0, 1'b0, ALB_CYC_ONE);
   endtask

   task automatic t_skip;
      op1(rq(ALB_OP_BIT_SKIP, ALB_CC_CARRY, 16'hFFFE, 16'h0000, 5'h00, 1'b0), 5'h15, 1'b0,
          1'b0, 16'h0000, 5'h15, 1'b0, 1'b1, ALB_CYC_TWO);
      op1(rq(ALB_OP_BIT_SKIP, ALB_CC_CARRY, 16'h7FFF, 16'h0000, 5'h0F, 1'b0), 5'h0A, 1'b1,
          1'b0, 16'h0000, 5'h0A, 1'b0, 1'b1, ALB_CYC_THREE);
      op1(rq(ALB_OP_BIT_SKIP, ALB_CC_CARRY, 16'h0001, 16'h0000, 5'h00, 1'b0), 5'h00, 1'b1,
          1'b0, 16'h0000, 5'h00, 1'b0, 1'b0, ALB_CYC_ONE);
   endtask

   task automatic t_branch;
      logic tk;
      for (int c = 0; c < 16; c++) begin
         for (int f = 0; f < 32; f++) begin
            tk = cc_ref(alb_cond_t'(c[3:0]), alb_flags_t'(f[4:0]));
            op1(rq(ALB_OP_BRANCH_COND, alb_cond_t'(c[3:0]), 16'h0000, 16'h0000, 5'h00, 1'b0),
                f[4:0], 1'b0, 1'b0, 16'h0000, f[4:0], tk, 1'b0,
                tk ? ALB_CYC_TWO : ALB_CYC_ONE);
         end
      end
      op1(rq(ALB_OP_BRANCH, ALB_CC_CARRY, 16'h0000, 16'h0000, 5'h00, 1'b0), 5'h0A, 1'b0,
          1'b0, 16'h0000, 5'h0A, 1'b1, 1'b0, ALB_CYC_TWO);
      op1(rq(ALB_OP_BRANCH_COMPUTED, ALB_CC_CARRY, 16'h0000, 16'h0000, 5'h00, 1'b0), 5'h15, 1'b0,
          1'b0, 16'h0000, 5'h15, 1'b1, 1'b0, ALB_CYC_TWO);
   endtask

   initial begin
      repeat (20000) @(posedge ref_clk_i);
      err_total++;
      results();
   end

   initial begin
      reset_n_i = 1'b0;
      req_valid_i = 1'b0;
      req_i = '0;
      flags_i = '0;
      next_two_word_i = 1'b0;
      t_reset();
      t_add_with_carry();
      t_reset();
      t_lit();
      t_shift();
      t_bits();
      t_skip();
      t_branch();
      results();
   end
endmodule
`default_nettype wire

//--- verilog/alb_cond.sv
// Purpose: branch condition decode from status flags
// Assumes: flags are the current status
// Notes: purely combinational
`timescale 1ns/100ps
`default_nettype none
module alb_cond (
   // condition and flags
   input wire alb_pkg::alb_cond_t cond_i,
   input wire alb_pkg::alb_flags_t flags_i,
   // result
   output logic taken_o
);
   import alb_pkg::*;
   logic sgn_lt;

   assign sgn_lt = flags_i.neg ^ flags_i.signed_wrap_flag;

   always_comb begin
      unique case (cond_i)
         ALB_CC_SGE: taken_o = !sgn_lt;
         ALB_CC_SGT: taken_o = !sgn_lt && !flags_i.zero;
         ALB_CC_SLT: taken_o = sgn_lt;
         ALB_CC_SLE: taken_o = sgn_lt || flags_i.zero;
         ALB_CC_UNSIGNED_AT_LEAST: taken_o = flags_i.carry;
         ALB_CC_UGT: taken_o = flags_i.carry && !flags_i.zero;
         ALB_CC_UNSIGNED_BELOW: taken_o = !flags_i.carry;
         ALB_CC_ULE: taken_o = !flags_i.carry || flags_i.zero;
         ALB_CC_CARRY: taken_o = flags_i.carry;
         ALB_CC_NO_CARRY: taken_o = !flags_i.carry;
         ALB_CC_WRAP: taken_o = flags_i.signed_wrap_flag;
         ALB_CC_NO_WRAP: taken_o = !flags_i.signed_wrap_flag;
         ALB_CC_ZERO: taken_o = flags_i.zero;
         ALB_CC_NOT_ZERO: taken_o = !flags_i.zero;
         ALB_CC_NEG: taken_o = flags_i.neg;
         ALB_CC_SIGN_CLEAR: taken_o = !flags_i.neg;
      endcase
   end
endmodule
`default_nettype wire

//--- verilog/alb_core.sv
// Purpose: alu datapath and branch resolution for one instruction per cycle
// Assumes: operands already fetched; caller writes result back when res_we_o
// Notes: all outputs registered, answer one cycle after the request
`timescale 1ns/100ps
`default_nettype none
module alb_core #(
   parameter int DATA_W = 16
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   // request
   input wire logic req_valid_i,
   input wire alb_pkg::alb_req_t req_i,
   input wire alb_pkg::alb_flags_t flags_i,
   input wire logic next_two_word_i,
   // answer
   output logic done_o,
   output logic [15:0] res_o,
   output logic res_we_o,
   output alb_pkg::alb_flags_t flags_o,
   output logic redirect_o,
   output logic skip_o,
   output logic [1:0] cycles_o,
   output logic [1:0] words_o
);
   import alb_pkg::*;

   if (DATA_W != ALB_W) begin : g_bad_width
      $error("alb_core supports only a 16-bit data path");
   end

   logic done_r, done_nxt;
   logic [15:0] res_r, res_nxt;
   logic we_r, we_nxt;
   alb_flags_t flags_r, flags_nxt;
   logic redir_r, redir_nxt;
   logic skip_r, skip_nxt;
   logic [1:0] cyc_r, cyc_nxt;
   logic [1:0] words_r, words_nxt;

   logic [15:0] a_eff;
   logic [16:0] sum;
   logic [4:0] nib_sum;
   logic sum_ovf;
   logic [15:0] shift_res;
   logic [15:0] bit_mask;
   logic [15:0] fbw_mask;
   logic fbw_val;
   logic cond_taken;

   alb_cond u_cond (
      .cond_i(req_i.cond),
      .flags_i(flags_i),
      .taken_o(cond_taken)
   );

   // long literal form uses only the low ten bits
   assign a_eff = (req_i.op == ALB_OP_ADD_CARRY_LIT) ?
                  {6'h00, req_i.opnd_a[ALB_LONG_LIT_W-1:0]} : req_i.opnd_a;
   assign sum = {1'b0, a_eff} + {1'b0, req_i.opnd_b} + {16'h0000, flags_i.carry};
   assign nib_sum = {1'b0, a_eff[3:0]} + {1'b0, req_i.opnd_b[3:0]} + {4'h0, flags_i.carry};
   assign sum_ovf = (a_eff[15] == req_i.opnd_b[15]) && (sum[15] != a_eff[15]);
   assign shift_res = $signed(req_i.opnd_a) >>> req_i.bit_pos;
   assign bit_mask = 16'h0001 << req_i.bit_pos[3:0];
   assign fbw_mask = 16'h0001 << req_i.opnd_b[3:0];
   assign fbw_val = req_i.take_zero ? flags_i.zero : flags_i.carry;

   always_comb begin
      done_nxt = req_valid_i;
      res_nxt = res_r;
      we_nxt = 1'b0;
      flags_nxt = flags_r;
      redir_nxt = 1'b0;
      skip_nxt = 1'b0;
      cyc_nxt = cyc_r;
      words_nxt = words_r;
      if (req_valid_i) begin
         flags_nxt = flags_i;
         cyc_nxt = ALB_CYC_ONE;
         words_nxt = ALB_WORDS_ONE;
         unique case (req_i.op)
            ALB_OP_ADD_CARRY, ALB_OP_ADD_CARRY_LIT: begin
               res_nxt = sum[15:0];
               we_nxt = 1'b1;
               flags_nxt.carry = sum[16];
               flags_nxt.digit_carry_flag = nib_sum[ALB_DIGIT_CARRY_POS];
               flags_nxt.neg = sum[15];
               flags_nxt.signed_wrap_flag = sum_ovf;
               flags_nxt.zero = (sum[15:0] == 16'h0000);
            end
            ALB_OP_SHIFT_ONE: begin
               res_nxt = {req_i.opnd_a[15], req_i.opnd_a[15:1]};
               we_nxt = 1'b1;
               flags_nxt.carry = req_i.opnd_a[0];
               flags_nxt.neg = req_i.opnd_a[15];
               flags_nxt.signed_wrap_flag = 1'b0;
               flags_nxt.zero = (req_i.opnd_a[15:1] == 15'h0000) && !req_i.opnd_a[15];
            end
            ALB_OP_SHIFT_MULTI: begin
               res_nxt = shift_res;
               we_nxt = 1'b1;
               flags_nxt.neg = shift_res[15];
               flags_nxt.zero = (shift_res == 16'h0000);
            end
            ALB_OP_FLAG_WRITE: begin
               res_nxt = fbw_val ? (req_i.opnd_a | fbw_mask) : (req_i.opnd_a & ~fbw_mask);
               we_nxt = 1'b1;
            end
            ALB_OP_BIT_CLEAR: begin
               res_nxt = req_i.opnd_a & ~bit_mask;
               we_nxt = 1'b1;
            end
            ALB_OP_BIT_SET: begin
               res_nxt = req_i.opnd_a | bit_mask;
               we_nxt = 1'b1;
            end
            ALB_OP_BIT_TOGGLE: begin
               res_nxt = req_i.opnd_a ^ bit_mask;
               we_nxt = 1'b1;
            end
            ALB_OP_BIT_SKIP: begin
               if ((req_i.opnd_a & bit_mask) == 16'h0000) begin
                  skip_nxt = 1'b1;
                  cyc_nxt = next_two_word_i ? ALB_CYC_THREE : ALB_CYC_TWO;
               end
            end
            ALB_OP_BRANCH_COND: begin
               redir_nxt = cond_taken;
               cyc_nxt = cond_taken ? ALB_CYC_TWO : ALB_CYC_ONE;
            end
            ALB_OP_BRANCH, ALB_OP_BRANCH_COMPUTED: begin
               redir_nxt = 1'b1;
               cyc_nxt = ALB_CYC_TWO;
            end
            ALB_OP_NOP: begin
               done_nxt = 1'b1;
            end
            default: begin
               done_nxt = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         done_r <= 1'b0;
         res_r <= ALB_RES_RST;
         we_r <= 1'b0;
         flags_r <= ALB_FLAGS_RST;
         redir_r <= 1'b0;
         skip_r <= 1'b0;
         cyc_r <= ALB_CNT_RST;
         words_r <= ALB_CNT_RST;
      end else begin
         done_r <= done_nxt;
         res_r <= res_nxt;
         we_r <= we_nxt;
         flags_r <= flags_nxt;
         redir_r <= redir_nxt;
         skip_r <= skip_nxt;
         cyc_r <= cyc_nxt;
         words_r <= words_nxt;
      end
   end

   assign done_o = done_r;
   assign res_o = res_r;
   assign res_we_o = we_r;
   assign flags_o = flags_r;
   assign redirect_o = redir_r;
   assign skip_o = skip_r;
   assign cycles_o = cyc_r;
   assign words_o = words_r;

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!reset_n_i);

   chk_carry_add_sum: assert property (
      req_valid_i && req_i.op == ALB_OP_ADD_CARRY |=> res_o == 16'($past(req_i.opnd_a)
         + $past(req_i.opnd_b) + {15'h0000, $past(flags_i.carry)}) && res_we_o && cycles_o == 2'h1)
      else $error("add with carry result or timing wrong");
   chk_long_lit_mask: assert property (
      req_valid_i && req_i.op == ALB_OP_ADD_CARRY_LIT |=> res_o == 16'({6'h00,
         $past(req_i.opnd_a[9:0])} + $past(req_i.opnd_b) + {15'h0000, $past(flags_i.carry)}))
      else $error("long literal add result wrong");
   chk_shift_one_sign: assert property (
      req_valid_i && req_i.op == ALB_OP_SHIFT_ONE |=> res_o[15] == $past(req_i.opnd_a[15])
         && flags_o.carry == $past(req_i.opnd_a[0]) && !flags_o.signed_wrap_flag)
      else $error("single arith shift lost sign or carry");
   chk_shift_multi_keep: assert property (
      req_valid_i && req_i.op == ALB_OP_SHIFT_MULTI |=> flags_o.carry == $past(flags_i.carry)
         && flags_o.signed_wrap_flag == $past(flags_i.signed_wrap_flag)
         && flags_o.zero == (res_o == 16'h0000))
      else $error("multi arith shift touched carry or wrap");
   chk_flag_bit_copy: assert property (
      req_valid_i && req_i.op == ALB_OP_FLAG_WRITE |=> res_o[$past(req_i.opnd_b[3:0])] ==
         ($past(req_i.take_zero) ? $past(flags_i.zero) : $past(flags_i.carry))
         && flags_o == $past(flags_i))
      else $error("flag to bit write wrong");
   chk_sge_resolve: assert property (
      req_valid_i && req_i.op == ALB_OP_BRANCH_COND && req_i.cond == ALB_CC_SGE
         |=> redirect_o == ($past(flags_i.neg) == $past(flags_i.signed_wrap_flag)))
      else $error("signed ge branch resolved wrong");
   chk_ugt_resolve: assert property (
      req_valid_i && req_i.op == ALB_OP_BRANCH_COND && req_i.cond == ALB_CC_UGT
         |=> redirect_o == ($past(flags_i.carry) && !$past(flags_i.zero)))
      else $error("unsigned gt branch resolved wrong");
   chk_sle_resolve: assert property (
      req_valid_i && req_i.op == ALB_OP_BRANCH_COND && req_i.cond == ALB_CC_SLE
         |=> redirect_o == ($past(flags_i.zero)
         || ($past(flags_i.neg) != $past(flags_i.signed_wrap_flag))))
      else $error("signed le branch resolved wrong");
   chk_ule_resolve: assert property (
      req_valid_i && req_i.op == ALB_OP_BRANCH_COND && req_i.cond == ALB_CC_ULE
         |=> redirect_o == (!$past(flags_i.carry) || $past(flags_i.zero)))
      else $error("unsigned le branch resolved wrong");
   chk_branch_cycles: assert property (
      req_valid_i && req_i.op == ALB_OP_BRANCH_COND |=> cycles_o == (redirect_o ? 2'h2 : 2'h1)
         && flags_o == $past(flags_i) && !res_we_o)
      else $error("conditional branch cycles or flags wrong");
   chk_sign_clear_only: assert property (
      req_valid_i && req_i.op == ALB_OP_BRANCH_COND && req_i.cond == ALB_CC_SIGN_CLEAR
         |=> redirect_o == !$past(flags_i.neg))
      else $error("sign clear branch resolved wrong");
   chk_bit_skip_time: assert property (
      req_valid_i && req_i.op == ALB_OP_BIT_SKIP
         |=> skip_o == !$past(req_i.opnd_a[req_i.bit_pos[3:0]])
         && cycles_o == (!skip_o ? 2'h1 : ($past(next_two_word_i) ? 2'h3 : 2'h2)))
      else $error("bit test skip wrong");
   chk_toggle_one_bit: assert property (
      req_valid_i && req_i.op == ALB_OP_BIT_TOGGLE |=> (res_o ^ $past(req_i.opnd_a)) ==
         (16'h0001 << $past(req_i.bit_pos[3:0])) && flags_o == $past(flags_i))
      else $error("bit toggle touched other bits or flags");
   chk_uncond_redirect: assert property (
      req_valid_i && (req_i.op == ALB_OP_BRANCH || req_i.op == ALB_OP_BRANCH_COMPUTED)
         |=> redirect_o && cycles_o == 2'h2 && flags_o == $past(flags_i))
      else $error("unconditional branch wrong");
endmodule
`default_nettype wire
